// File: frcrs_map.svh
// Purpose: offsets, field positions, reset values for the rate control and result status block
// Assumes: 8-bit register port, 10 MHz ref_clk
// Notes: offsets are local choices; see hand-over
// Overview of operation
// - config bits 1:0 select the transfer data rate.
// - config bit 2 stored, no effect, read back on rate select bit 2 in alternate mode.
// - precompensation-off bit survives software reset.
// - density output high on hardware reset, untouched by software resets.
// - result phase presents status bytes of the just-finished command.
// - status 0 bits 7:6 hold the termination code.
// - status 0 bit 5 set on seek, relative seek or recalibrate completion.
// - status 0 bit 4 set on track zero fault.
// - status 0 bit 2 head, bits 1:0 drive, bit 3 zero.
// - status 1 bit 7 set past final sector or missing terminal count.
// - status 1 bit 5 set on ID or data CRC failure.
// - status 1 bit 4 set on overrun or underrun.
// - status 1 bit 2 set when sector or sequence not found.
// - status 1 bit 1 set when write protect rises during write or format.
// - status 1 bit 0 set when address mark missing.
// - rate field 250 Kbps after hardware reset, kept over software reset.
`ifndef FRCRS_MAP_SVH
`define FRCRS_MAP_SVH
`define FRCRS_OFF_CONFIG 4'h0
`define FRCRS_OFF_RATE 4'h1
`define FRCRS_OFF_ST0 4'h2
`define FRCRS_OFF_ST1 4'h3
`define FRCRS_OFF_IRQ_STAT 4'h4
`define FRCRS_OFF_IRQ_MASK 4'h5
`define FRCRS_OFF_MODE 4'h6
`define FRCRS_RATE_250K 2'h2
`define FRCRS_RATE_300K 2'h1
`define FRCRS_CFG_PRECOMP_BIT 2
`define FRCRS_IRQ_RESULT_BIT 0
`define FRCRS_IRQ_WP_BIT 1
`endif

// File: frcrs_pkg.sv
// Purpose: types for the rate control and result status block
// Assumes: nothing
// Notes: none
package frcrs_pkg;
    typedef enum logic [1:0] {
        FRCRS_TC_NORMAL = 2'h0,
        FRCRS_TC_ABNORMAL = 2'h1,
        FRCRS_TC_INVALID = 2'h2,
        FRCRS_TC_POLLING = 2'h3
    } frcrs_term_e;

    typedef enum logic [1:0] {
        FRCRS_IDLE = 2'h0,
        FRCRS_EXEC = 2'h1,
        FRCRS_RESULT = 2'h2
    } frcrs_phase_e;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } frcrs_bus_s;

    // one-cycle event pulses plus held levels (term, head, drive, write_cmd) from the command engine
    typedef struct packed {
        logic cmd_start;
        logic cmd_done;
        frcrs_term_e term;
        logic seek_done;
        logic track_zero_input_fault;
        logic end_of_track;
        logic tc_missing;
        logic crc_error;
        logic overrun;
        logic sector_missing;
        logic hdr_sync_absent;
        logic write_cmd;
        logic head;
        logic [1:0] drive;
    } frcrs_evt_s;

    typedef struct packed {
        logic [1:0] rate;
        logic precomp_off;
        logic density;
        logic alt_mode;
        frcrs_phase_e phase;
        frcrs_term_e term;
        logic seek_done;
        logic track_zero_input_fault;
        logic head;
        logic [1:0] drive;
        logic end_of_track;
        logic crc_error;
        logic overrun;
        logic sector_missing;
        logic write_blocked;
        logic hdr_sync_absent;
        logic [1:0] wp_sync;
        logic wp_prev;
        logic [1:0] irq_stat;
        logic [1:0] irq_mask;
        logic [7:0] rdata;
    } frcrs_state_s;
endpackage

// File: frcrs_top.sv
// Purpose: configuration control register and result status bytes 0 and 1
// Assumes: events come from the command engine on ref_clk; write protect is a raw pin
// Notes: software reset is a one-cycle pulse from the drive output or rate select logic
//
// Added by the designer: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`include "frcrs_map.svh"
module frcrs_top (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic soft_reset,
    input wire frcrs_pkg::frcrs_bus_s bus,
    output logic [7:0] rdata,
    input wire frcrs_pkg::frcrs_evt_s evt,
    input wire logic write_protect_pin,
    output logic [1:0] transfer_rate_field,
    output logic density_output,
    output logic result_phase,
    output logic irq
);
    frcrs_pkg::frcrs_state_s s_q;
    frcrs_pkg::frcrs_state_s s_d;
    logic wp_rise;
    logic wr_cfg;
    logic [1:0] ev;

    always_comb
    begin
        s_d = s_q;
        wr_cfg = bus.wr && (bus.addr == `FRCRS_OFF_CONFIG);
        s_d.wp_sync = {s_q.wp_sync[0], write_protect_pin};
        s_d.wp_prev = s_q.wp_sync[1];
        wp_rise = s_q.wp_sync[1] && !s_q.wp_prev;
        // bits 7:3 ignored on write, software keeps them zero
        if (wr_cfg)
        begin
            s_d.rate = bus.wdata[1:0];
            s_d.precomp_off = bus.wdata[`FRCRS_CFG_PRECOMP_BIT];
        end
        // rate density follows the rate; a soft reset touches none of these
        s_d.density = (s_d.rate == `FRCRS_RATE_250K) || (s_d.rate == `FRCRS_RATE_300K);
        if (bus.wr && (bus.addr == `FRCRS_OFF_MODE))
        begin
            s_d.alt_mode = bus.wdata[0];
        end
        ev = 2'h0;
        case (s_q.phase)
            frcrs_pkg::FRCRS_IDLE:
            begin
                if (evt.cmd_start)
                begin
                    s_d.phase = frcrs_pkg::FRCRS_EXEC;
                    s_d.seek_done = 1'b0;
                    s_d.track_zero_input_fault = 1'b0;
                    s_d.end_of_track = 1'b0;
                    s_d.crc_error = 1'b0;
                    s_d.overrun = 1'b0;
                    s_d.sector_missing = 1'b0;
                    s_d.write_blocked = 1'b0;
                    s_d.hdr_sync_absent = 1'b0;
                end
            end
            frcrs_pkg::FRCRS_EXEC:
            begin
                // flags accumulate over the command so a late error is not lost
                if (evt.seek_done) s_d.seek_done = 1'b1;
                if (evt.track_zero_input_fault) s_d.track_zero_input_fault = 1'b1;
                if (evt.end_of_track || evt.tc_missing) s_d.end_of_track = 1'b1;
                if (evt.crc_error) s_d.crc_error = 1'b1;
                if (evt.overrun) s_d.overrun = 1'b1;
                if (evt.sector_missing) s_d.sector_missing = 1'b1;
                if (evt.write_cmd && wp_rise)
                begin
                    s_d.write_blocked = 1'b1;
                    ev[`FRCRS_IRQ_WP_BIT] = 1'b1;
                end
                if (evt.hdr_sync_absent) s_d.hdr_sync_absent = 1'b1;
                if (evt.cmd_done)
                begin
                    s_d.term = evt.term;
                    s_d.head = evt.head;
                    s_d.drive = evt.drive;
                    s_d.phase = frcrs_pkg::FRCRS_RESULT;
                    ev[`FRCRS_IRQ_RESULT_BIT] = 1'b1;
                end
            end
            frcrs_pkg::FRCRS_RESULT:
            begin
                // reading byte 1 ends the result phase
                if (bus.rd && (bus.addr == `FRCRS_OFF_ST1))
                begin
                    s_d.phase = frcrs_pkg::FRCRS_IDLE;
                end
                else if (evt.cmd_start)
                begin
                    // a new command must not inherit the flags of the one still being reported
                    s_d.phase = frcrs_pkg::FRCRS_EXEC;
                    s_d.seek_done = 1'b0;
                    s_d.track_zero_input_fault = 1'b0;
                    s_d.end_of_track = 1'b0;
                    s_d.crc_error = 1'b0;
                    s_d.overrun = 1'b0;
                    s_d.sector_missing = 1'b0;
                    s_d.write_blocked = 1'b0;
                    s_d.hdr_sync_absent = 1'b0;
                end
            end
            default:
            begin
                s_d.phase = frcrs_pkg::FRCRS_IDLE;
            end
        endcase
        if (soft_reset)
        begin
            s_d.phase = frcrs_pkg::FRCRS_IDLE;
        end
        // set wins over the write-one clear
        if (bus.wr && (bus.addr == `FRCRS_OFF_IRQ_STAT)) s_d.irq_stat = s_q.irq_stat & ~bus.wdata[1:0];
        s_d.irq_stat = s_d.irq_stat | ev;
        if (bus.wr && (bus.addr == `FRCRS_OFF_IRQ_MASK)) s_d.irq_mask = bus.wdata[1:0];
        s_d.rdata = 8'h00;
        if (bus.rd)
        begin
            if (bus.addr == `FRCRS_OFF_RATE)
                s_d.rdata = {5'h00, s_q.alt_mode & s_q.precomp_off, s_q.rate};
            else if (bus.addr == `FRCRS_OFF_ST0)
                s_d.rdata = {s_q.term, s_q.seek_done, s_q.track_zero_input_fault, 1'b0, s_q.head, s_q.drive};
            else if (bus.addr == `FRCRS_OFF_ST1)
                s_d.rdata = {s_q.end_of_track, 1'b0, s_q.crc_error, s_q.overrun, 1'b0,
                             s_q.sector_missing, s_q.write_blocked, s_q.hdr_sync_absent};
            else if (bus.addr == `FRCRS_OFF_IRQ_STAT)
                s_d.rdata = {6'h00, s_q.irq_stat};
            else if (bus.addr == `FRCRS_OFF_IRQ_MASK)
                s_d.rdata = {6'h00, s_q.irq_mask};
            else if (bus.addr == `FRCRS_OFF_MODE)
                s_d.rdata = {7'h00, s_q.alt_mode};
            else
                s_d.rdata = 8'h00;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            s_q <= '0;
            s_q.rate <= `FRCRS_RATE_250K;
            s_q.density <= 1'b1;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign rdata = s_q.rdata;
    assign transfer_rate_field = s_q.rate;
    assign density_output = s_q.density;
    assign result_phase = (s_q.phase == frcrs_pkg::FRCRS_RESULT);
    assign irq = |(s_q.irq_stat & s_q.irq_mask);

    a_rate_write: assert property (@(posedge ref_clk) disable iff (!rstn)
        (bus.wr && bus.addr == `FRCRS_OFF_CONFIG) |=> (transfer_rate_field == $past(bus.wdata[1:0])))
        else $error("rate field not taken from write");
    a_rate_softrst: assert property (@(posedge ref_clk) disable iff (!rstn)
        (soft_reset && !bus.wr) |=> $stable(transfer_rate_field) && $stable(s_q.precomp_off))
        else $error("soft reset changed rate or precomp");
    a_dens_track: assert property (@(posedge ref_clk) disable iff (!rstn)
        density_output == (transfer_rate_field[1] ^ transfer_rate_field[0]))
        else $error("density does not follow rate");
    a_st0_zero: assert property (@(posedge ref_clk) disable iff (!rstn)
        (bus.rd && bus.addr == `FRCRS_OFF_ST0) |=> (rdata[3] == 1'b0))
        else $error("status 0 bit 3 not zero");
    a_st1_unused: assert property (@(posedge ref_clk) disable iff (!rstn)
        (bus.rd && bus.addr == `FRCRS_OFF_ST1) |=> (rdata[6] == 1'b0 && rdata[3] == 1'b0))
        else $error("status 1 unused bits set");
    sequence s_done_exec;
        result_phase == 1'b0 && s_q.phase == frcrs_pkg::FRCRS_EXEC && evt.cmd_done && !soft_reset;
    endsequence
    a_result_entry: assert property (@(posedge ref_clk) disable iff (!rstn)
        s_done_exec |=> result_phase && s_q.term == $past(evt.term))
        else $error("result phase not entered");
    a_crc_sticky: assert property (@(posedge ref_clk) disable iff (!rstn)
        (s_q.phase == frcrs_pkg::FRCRS_EXEC && evt.crc_error && !evt.cmd_start) |=> s_q.crc_error)
        else $error("crc flag missed");
    a_eot_flag: assert property (@(posedge ref_clk) disable iff (!rstn)
        (s_q.phase == frcrs_pkg::FRCRS_EXEC && evt.tc_missing) |=> s_q.end_of_track)
        else $error("end of track flag missed");
    a_prec_read: assert property (@(posedge ref_clk) disable iff (!rstn)
        (bus.rd && bus.addr == `FRCRS_OFF_RATE) |=> (rdata[2] == ($past(s_q.alt_mode) & $past(s_q.precomp_off))))
        else $error("precomp readback wrong");
endmodule

// File: frcrs_cmd_model.sv
// Purpose: command engine stand-in that emits one command's event pulses
// Assumes: go is a one-cycle pulse from the bench
// Notes: term, head and drive are inverted and write_cmd held low between commands so stale values are never taken as live ones
`timescale 1ns/1ps
module frcrs_cmd_model (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic go,
    input wire frcrs_pkg::frcrs_evt_s cfg,
    output frcrs_pkg::frcrs_evt_s evt
);
    logic [3:0] cnt_q;
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            cnt_q <= 4'h0;
        else if (go)
            cnt_q <= 4'h1;
        else if (cnt_q != 4'h0)
            cnt_q <= (cnt_q == 4'h9) ? 4'h0 : cnt_q + 4'h1;
    end
    always_comb
    begin
        evt = cfg;
        evt.cmd_start = (cnt_q == 4'h1);
        evt.cmd_done = (cnt_q == 4'h8);
        evt.write_cmd = cfg.write_cmd && (cnt_q != 4'h0);
        if (cnt_q != 4'h4)
            {evt.seek_done, evt.track_zero_input_fault, evt.end_of_track, evt.tc_missing, evt.crc_error, evt.overrun,
                evt.sector_missing, evt.hdr_sync_absent} = 8'h00;
        if (cnt_q == 4'h0)
        begin
            evt.term = frcrs_pkg::frcrs_term_e'(~cfg.term);
            {evt.head, evt.drive} = ~{cfg.head, cfg.drive};
        end
    end
endmodule

// File: frcrs_top_tb.sv
// Purpose: register and result status checks of the rate control block
// Assumes: register offsets from the map header
// Notes: flags vector f is {seek, track_zero_input, eot, tc, crc, ovr, sector, mark}
`timescale 1ns/1ps
`include "frcrs_map.svh"
module frcrs_top_tb;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic soft_reset = 1'b0;
    logic wp_pin = 1'b0;
    logic go = 1'b0;
    frcrs_pkg::frcrs_bus_s bus = '0;
    frcrs_pkg::frcrs_evt_s cfg = '0;
    frcrs_pkg::frcrs_evt_s evt;
    logic [7:0] rdata;
    logic [7:0] got;
    logic [1:0] rate;
    logic density;
    logic res_ph;
    logic irq;
    int mismatches = 0;
    int tests_run = 0;
    int cyc = 0;
    always #50 ref_clk = ~ref_clk;
    frcrs_top dut_u (.ref_clk(ref_clk), .rstn(rstn), .soft_reset(soft_reset), .bus(bus), .rdata(rdata),
        .evt(evt), .write_protect_pin(wp_pin), .transfer_rate_field(rate), .density_output(density),
        .result_phase(res_ph), .irq(irq));
    frcrs_cmd_model eng_u (.ref_clk(ref_clk), .rstn(rstn), .go(go), .cfg(cfg), .evt(evt));
    task automatic end_sim;
        $display("tests_run %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] exp, input logic [7:0] act);
        tests_run++;
        if (act !== exp)
        begin
            mismatches++;
            $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, act);
        end
    endtask
    // one strobe cycle; read data sampled in the cycle after the strobe
    task automatic acc(input logic r, input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        bus.addr <= a;
        bus.wdata <= d;
        bus.rd <= r;
        bus.wr <= ~r;
        @(posedge ref_clk);
        bus.rd <= 1'b0;
        bus.wr <= 1'b0;
        #1 got = rdata;
    endtask
    task automatic cmd(input logic [1:0] tc, input logic [7:0] f, input logic [2:0] hd, input logic wp);
        @(posedge ref_clk);
        cfg.term <= frcrs_pkg::frcrs_term_e'(tc);
        {cfg.seek_done, cfg.track_zero_input_fault, cfg.end_of_track, cfg.tc_missing, cfg.crc_error, cfg.overrun,
            cfg.sector_missing, cfg.hdr_sync_absent} <= f;
        {cfg.head, cfg.drive} <= hd;
        cfg.write_cmd <= wp;
        go <= 1'b1;
        @(posedge ref_clk);
        go <= 1'b0;
        wp_pin <= wp;
        for (int i = 0; i < 20 && res_ph !== 1'b1; i++) @(posedge ref_clk);
        chk(8'h03, {6'h0, res_ph, irq});
        acc(1'b1, `FRCRS_OFF_ST0, 8'h00);
        chk({tc, f[7:6], 1'b0, hd}, got);
        acc(1'b1, `FRCRS_OFF_ST1, 8'h00);
        chk({f[5] | f[4], 1'b0, f[3:2], 1'b0, f[1], wp, f[0]}, got);
        chk(8'h01, {6'h0, res_ph, irq});
        acc(1'b1, `FRCRS_OFF_IRQ_STAT, 8'h00);
        chk({6'h0, wp, 1'b1}, got);
        acc(1'b0, `FRCRS_OFF_IRQ_MASK, 8'h00);
        chk(8'h00, {7'h0, irq});
        acc(1'b0, `FRCRS_OFF_IRQ_MASK, 8'h03);
        chk(8'h01, {7'h0, irq});
        acc(1'b0, `FRCRS_OFF_IRQ_STAT, 8'h03);
        wp_pin <= 1'b0;
        chk(8'h00, {7'h0, irq});
    endtask
    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            mismatches++;
            end_sim();
        end
    end
    initial
    begin
        repeat (3) @(posedge ref_clk);
        rstn <= 1'b1;
        #1 chk(8'h06, {5'h0, density, rate});
        acc(1'b1, `FRCRS_OFF_RATE, 8'h00);
        chk(8'h02, got);
        acc(1'b0, `FRCRS_OFF_MODE, 8'h01);
        acc(1'b0, `FRCRS_OFF_CONFIG, 8'h05);
        chk(8'h05, {5'h0, density, rate});
        acc(1'b1, `FRCRS_OFF_RATE, 8'h00);
        chk(8'h05, got);
        acc(1'b1, `FRCRS_OFF_CONFIG, 8'h00);
        chk(8'h00, got);
        acc(1'b0, `FRCRS_OFF_CONFIG, 8'h03);
        chk(8'h03, {5'h0, density, rate});
        acc(1'b0, `FRCRS_OFF_CONFIG, 8'h04);
        @(posedge ref_clk);
        soft_reset <= 1'b1;
        @(posedge ref_clk);
        soft_reset <= 1'b0;
        #1 chk(8'h00, {5'h0, density, rate});
        acc(1'b1, `FRCRS_OFF_RATE, 8'h00);
        chk(8'h04, got);
        acc(1'b1, 4'hF, 8'h00);
        chk(8'h00, got);
        @(posedge ref_clk);
        rstn <= 1'b0;
        @(posedge ref_clk);
        rstn <= 1'b1;
        #1 chk(8'h06, {5'h0, density, rate});
        acc(1'b0, `FRCRS_OFF_IRQ_MASK, 8'h03);
        cmd(2'h0, 8'h81, 3'h1, 1'b0);
        cmd(2'h1, 8'h6C, 3'h6, 1'b0);
        cmd(2'h2, 8'h12, 3'h3, 1'b0);
        cmd(2'h3, 8'h00, 3'h4, 1'b1);
        end_sim();
    end
endmodule
